// ---- rtcal_top.sv ----
// Operation
// - Alarm flag sets when at least one alarm register is enabled and all enabled ones equal their counters.
// - Bit 7 enables a register; only enabled registers join the compare.
// - Power-on reset clears alarm enables; alarm values survive both resets.
// - Unused alarm bits read zero and ignore writes.
// - Both resets clear carry and alarm interrupt enables.
// - Carry flag sets on seconds carry or 64 Hz carry during read.
// - Writing 0 clears the carry flag; writing 1 sets it.
// - Carry interrupt is carry flag and carry enable (bit 4).
// - Alarm interrupt is alarm flag and alarm enable (bit 3).
// - Writing 0 clears the alarm flag; writing 1 leaves it alone.
// - Control bits 6, 5, 2, 1 ignore writes.
`timescale 1ns/1ns
`default_nettype none

module rtcal_top (
	// Clock and power-on reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Manual reset pin, asynchronous to pclk
	input  wire logic        manual_reset_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Live BCD counters, same clock
	input  wire logic [7:0]  second_counter,
	input  wire logic [7:0]  minute_counter,
	input  wire logic [7:0]  hour_counter,
	input  wire logic [7:0]  weekday_counter,
	input  wire logic [7:0]  day_counter,
	input  wire logic [7:0]  month_counter,
	// Counter events, same clock
	input  wire logic        second_carry,
	input  wire logic        tick64_carry,
	input  wire logic        tick64_read,
	// Interrupts
	output logic             carry_irq,
	output logic             alarm_irq,
	output logic             irq
);

	localparam int unsigned N = rtcal_pkg::NUM_ALARMS;

	typedef struct packed {
		logic [N-1:0][7:0]                  alarm;
		logic                               carry_flag;
		logic                               alarm_flag;
		logic                               carry_irq_enable;
		logic                               alarm_irq_enable;
		logic [rtcal_pkg::IRQ_BITS-1:0]     sts;
		logic [rtcal_pkg::IRQ_BITS-1:0]     msk;
		logic                               match_prev;
		logic [rtcal_pkg::SYNC_DEPTH-1:0]   mr_sync;
		logic                               mr_active;
		logic                               pready;
		logic                               pslverr;
		logic [31:0]                        prdata;
		logic                               carry_irq;
		logic                               alarm_irq;
		logic                               irq;
	} rtcal_state_s;

	rtcal_state_s q;
	rtcal_state_s d;

	logic [N-1:0][7:0] counters;
	logic              match;
	logic              access;
	logic              wr;
	logic              rd;
	logic              setup;
	logic              mapped;
	logic [7:0]        rd_val;
	logic              ctl_wr;
	logic              cf_set;
	logic              af_set;

	assign counters = {month_counter, day_counter, weekday_counter,
		hour_counter, minute_counter, second_counter};

	rtcal_match #(
		.N(N)
	) u_match (
		.alarm  (q.alarm),
		.counter(counters),
		.match  (match)
	);

	assign setup = psel && !penable;
	assign access = psel && penable && q.pready;
	assign wr = access && pwrite && !q.pslverr && pstrb[0];
	assign rd = access && !pwrite && !q.pslverr;
	assign ctl_wr = wr && (paddr == rtcal_pkg::OFF_CONTROL);
	assign cf_set = second_carry || (tick64_carry && tick64_read);
	// Edge of the match, so a clear during a long match is not undone
	assign af_set = match && !q.match_prev;

	// Read value and decode for the address on the bus
	always_comb begin
		rd_val = 8'h00;
		mapped = 1'b1;
		case (paddr)
			rtcal_pkg::OFF_CONTROL: begin
				rd_val[rtcal_pkg::CTL_CARRY_FLAG] = q.carry_flag;
				rd_val[rtcal_pkg::CTL_CARRY_IE] = q.carry_irq_enable;
				rd_val[rtcal_pkg::CTL_ALARM_IE] = q.alarm_irq_enable;
				rd_val[rtcal_pkg::CTL_ALARM_FLAG] = q.alarm_flag;
			end
			rtcal_pkg::OFF_IRQ_STATUS: begin
				rd_val[rtcal_pkg::IRQ_BITS-1:0] = q.sts;
			end
			rtcal_pkg::OFF_IRQ_MASK: begin
				rd_val[rtcal_pkg::IRQ_BITS-1:0] = q.msk;
			end
			default: begin
				mapped = 1'b0;
				for (int i = 0; i < N; i++) begin
					if (paddr == rtcal_pkg::ALARM_OFF[i]) begin
						rd_val = q.alarm[i] & rtcal_pkg::ALARM_WMASK[i];
						mapped = 1'b1;
					end
				end
			end
		endcase
	end

	always_comb begin
		d = q;
		// No wait states: read data and answer settle in the setup cycle
		d.pready = setup;
		d.pslverr = setup && !mapped;
		if (setup) begin
			d.prdata = {24'h000000, rd_val};
		end

		// Manual reset pin: act once the last two stages agree
		d.mr_sync = {q.mr_sync[rtcal_pkg::SYNC_DEPTH-2:0], manual_reset_n};
		if (q.mr_sync[2] == q.mr_sync[1]) begin
			d.mr_active = !q.mr_sync[2];
		end

		// Unused bits never store, so they read back as zero
		for (int i = 0; i < N; i++) begin
			if (wr && paddr == rtcal_pkg::ALARM_OFF[i]) begin
				d.alarm[i] = pwdata[7:0] & rtcal_pkg::ALARM_WMASK[i];
			end
		end

		d.match_prev = match;

		if (ctl_wr) begin
			d.carry_flag = pwdata[rtcal_pkg::CTL_CARRY_FLAG];
			d.carry_irq_enable = pwdata[rtcal_pkg::CTL_CARRY_IE];
			d.alarm_irq_enable = pwdata[rtcal_pkg::CTL_ALARM_IE];
			if (!pwdata[rtcal_pkg::CTL_ALARM_FLAG]) begin
				d.alarm_flag = 1'b0;
			end
		end
		// Hardware set wins over a software clear in the same cycle
		if (cf_set) begin
			d.carry_flag = 1'b1;
		end
		if (af_set) begin
			d.alarm_flag = 1'b1;
		end
		if (q.mr_active) begin
			d.carry_irq_enable = 1'b0;
			d.alarm_irq_enable = 1'b0;
		end

		if (wr && paddr == rtcal_pkg::OFF_IRQ_MASK) begin
			d.msk = pwdata[rtcal_pkg::IRQ_BITS-1:0];
		end
		if (rd && paddr == rtcal_pkg::OFF_IRQ_STATUS) begin
			d.sts = rtcal_pkg::IRQ_RESET;
		end
		d.sts[rtcal_pkg::IRQ_BIT_CARRY] = d.sts[rtcal_pkg::IRQ_BIT_CARRY] || cf_set;
		d.sts[rtcal_pkg::IRQ_BIT_ALARM] = d.sts[rtcal_pkg::IRQ_BIT_ALARM] || af_set;

		d.carry_irq = d.carry_flag && d.carry_irq_enable;
		d.alarm_irq = d.alarm_flag && d.alarm_irq_enable;
		d.irq = |(d.sts & d.msk);
	end

	// Alarm times are left out of the reset on purpose: only their enables clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < N; i++) begin
				q.alarm[i][rtcal_pkg::ALM_ENABLE_BIT] <=
					rtcal_pkg::ALM_RESET[rtcal_pkg::ALM_ENABLE_BIT];
			end
			q.carry_flag <= 1'b0;
			q.alarm_flag <= 1'b0;
			q.carry_irq_enable <= 1'b0;
			q.alarm_irq_enable <= 1'b0;
			q.sts <= rtcal_pkg::IRQ_RESET;
			q.msk <= rtcal_pkg::IRQ_RESET;
			q.match_prev <= 1'b0;
			q.mr_sync <= '1;
			q.mr_active <= 1'b0;
			q.pready <= 1'b0;
			q.pslverr <= 1'b0;
			q.prdata <= '0;
			q.carry_irq <= 1'b0;
			q.alarm_irq <= 1'b0;
			q.irq <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign pready = q.pready;
	assign prdata = q.prdata;
	assign pslverr = q.pslverr;
	assign carry_irq = q.carry_irq;
	assign alarm_irq = q.alarm_irq;
	assign irq = q.irq;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_setup_read(logic [7:0] off);
		psel && !penable && !pwrite && paddr == off;
	endsequence

	sequence s_ctl_write(int unsigned bitpos, logic val);
		ctl_wr && pwdata[bitpos] == val;
	endsequence

	property p_alarm_set;
		match && !q.match_prev |=> q.alarm_flag ##1 q.alarm_flag || !ctl_wr;
	endproperty
	a_alarm_set: assert property (p_alarm_set)
		else $error("alarm flag not set on new match");

	property p_no_enable;
		(q.alarm[0][7] | q.alarm[1][7] | q.alarm[2][7] | q.alarm[3][7]
			| q.alarm[4][7] | q.alarm[5][7]) == 1'b0 && !q.alarm_flag
			|=> !q.alarm_flag;
	endproperty
	a_no_enable: assert property (p_no_enable)
		else $error("alarm flag set with no slot enabled");

	property p_carry_set;
		cf_set |=> q.carry_flag;
	endproperty
	a_carry_set: assert property (p_carry_set)
		else $error("carry flag missed an event");

	property p_carry_clear;
		s_ctl_write(rtcal_pkg::CTL_CARRY_FLAG, 1'b0) and !cf_set |=> !q.carry_flag;
	endproperty
	a_carry_clear: assert property (p_carry_clear)
		else $error("carry flag not cleared by write of 0");

	property p_af_write_one;
		s_ctl_write(rtcal_pkg::CTL_ALARM_FLAG, 1'b1) and !af_set
			|=> q.alarm_flag == $past(q.alarm_flag);
	endproperty
	a_af_write_one: assert property (p_af_write_one)
		else $error("writing 1 changed the alarm flag");

	property p_carry_irq;
		q.carry_flag && q.carry_irq_enable && !ctl_wr && !q.mr_active
			|=> carry_irq;
	endproperty
	a_carry_irq: assert property (p_carry_irq)
		else $error("carry interrupt missing");

	property p_alarm_irq_off;
		!q.alarm_irq_enable && !ctl_wr |=> !alarm_irq;
	endproperty
	a_alarm_irq_off: assert property (p_alarm_irq_off)
		else $error("alarm interrupt with enable low");

	property p_manual_reset;
		q.mr_active |=> !q.carry_irq_enable && !q.alarm_irq_enable;
	endproperty
	a_manual_reset: assert property (p_manual_reset)
		else $error("manual reset left an interrupt enable set");

	property p_ctl_reserved;
		s_setup_read(rtcal_pkg::OFF_CONTROL) |=> prdata[6:5] == 2'h0
			&& prdata[2:1] == 2'h0 && pready;
	endproperty
	a_ctl_reserved: assert property (p_ctl_reserved)
		else $error("reserved control bits read nonzero");

	property p_hour_unused;
		s_setup_read(rtcal_pkg::OFF_HOUR_ALARM) |=> prdata[6] == 1'b0;
	endproperty
	a_hour_unused: assert property (p_hour_unused)
		else $error("unused hour alarm bit read nonzero");

	property p_enable_kept;
		q.mr_active && !wr |=> $stable(q.alarm);
	endproperty
	a_enable_kept: assert property (p_enable_kept)
		else $error("alarm register changed by manual reset");

endmodule

`default_nettype wire

// ---- rtcal_pkg.sv ----
package rtcal_pkg;

	// Alarm slots in compare order
	localparam int unsigned NUM_ALARMS = 6;
	localparam int unsigned SLOT_SECOND = 0;
	localparam int unsigned SLOT_MINUTE = 1;
	localparam int unsigned SLOT_HOUR = 2;
	localparam int unsigned SLOT_WEEKDAY = 3;
	localparam int unsigned SLOT_DAY = 4;
	localparam int unsigned SLOT_MONTH = 5;

	// Byte offsets on the register bus
	localparam logic [7:0] OFF_SECOND_ALARM = 8'h00;
	localparam logic [7:0] OFF_MINUTE_ALARM = 8'h04;
	localparam logic [7:0] OFF_HOUR_ALARM = 8'h08;
	localparam logic [7:0] OFF_WEEKDAY_ALARM = 8'h0c;
	localparam logic [7:0] OFF_DAY_ALARM = 8'h10;
	localparam logic [7:0] OFF_MONTH_ALARM = 8'h14;
	localparam logic [7:0] OFF_CONTROL = 8'h18;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h1c;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
	localparam logic [NUM_ALARMS-1:0][7:0] ALARM_OFF = {
		OFF_MONTH_ALARM, OFF_DAY_ALARM, OFF_WEEKDAY_ALARM,
		OFF_HOUR_ALARM, OFF_MINUTE_ALARM, OFF_SECOND_ALARM};

	// Alarm register layout: enable on top, storable bits per slot
	localparam int unsigned ALM_ENABLE_BIT = 7;
	localparam logic [NUM_ALARMS-1:0][7:0] ALARM_WMASK = {
		8'h9f, 8'hbf, 8'h87, 8'hbf, 8'hff, 8'hff};
	localparam logic [7:0] ALM_VALUE_MASK = 8'h7f;
	localparam logic [7:0] ALM_RESET = 8'h00;

	// Control register fields
	localparam int unsigned CTL_CARRY_FLAG = 7;
	localparam int unsigned CTL_CARRY_IE = 4;
	localparam int unsigned CTL_ALARM_IE = 3;
	localparam int unsigned CTL_ALARM_FLAG = 0;

	// Interrupt status and mask layout
	localparam int unsigned IRQ_BIT_CARRY = 0;
	localparam int unsigned IRQ_BIT_ALARM = 1;
	localparam int unsigned IRQ_BITS = 2;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	// Manual reset input synchroniser depth
	localparam int unsigned SYNC_DEPTH = 3;

endpackage

// ---- rtcal_match.sv ----
`timescale 1ns/1ns
`default_nettype none

// Alarm compare: every enabled slot must equal its counter
module rtcal_match #(
	parameter int unsigned N = rtcal_pkg::NUM_ALARMS
) (
	// Alarm registers and live counters, slot-major
	input  wire logic [N-1:0][7:0] alarm,
	input  wire logic [N-1:0][7:0] counter,
	// Result
	output logic                   match
);

	logic [N-1:0] slot_ok;
	logic [N-1:0] slot_en;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_slot
			assign slot_en[g] = alarm[g][rtcal_pkg::ALM_ENABLE_BIT];
			assign slot_ok[g] = !slot_en[g] ||
				((alarm[g] & rtcal_pkg::ALM_VALUE_MASK) ==
				(counter[g] & rtcal_pkg::ALM_VALUE_MASK));
		end
	endgenerate

	// With no slot enabled the all-match would be vacuously true
	assign match = (|slot_en) && (&slot_ok);

endmodule

`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	logic        pclk;
	logic        presetn;
	logic        manual_reset_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [7:0]  cnt [6];
	logic        second_carry;
	logic        tick64_carry;
	logic        tick64_read;
	logic        carry_irq;
	logic        alarm_irq;
	logic        irq;
	logic [7:0]  h;
	logic [7:0]  d;
	logic [7:0]  wk;
	logic [7:0]  mo;
	logic [7:0]  mi;
	logic [3:0]  pstrb;
	logic [32:0] exp_q [$];
	int          err_count;
	int          total_checks;
	// Writable bits per alarm slot, second first
	logic [7:0]  wmask [6] = '{8'hff, 8'hff, 8'hbf, 8'h87, 8'hbf, 8'h9f};

	rtcal_top dut (
		.pclk           (pclk),
		.presetn        (presetn),
		.manual_reset_n (manual_reset_n),
		.psel           (psel),
		.penable        (penable),
		.pwrite         (pwrite),
		.paddr          (paddr),
		.pwdata         (pwdata),
		.pstrb          (pstrb),
		.pready         (pready),
		.prdata         (prdata),
		.pslverr        (pslverr),
		.second_counter (cnt[rtcal_pkg::SLOT_SECOND]),
		.minute_counter (cnt[rtcal_pkg::SLOT_MINUTE]),
		.hour_counter   (cnt[rtcal_pkg::SLOT_HOUR]),
		.weekday_counter(cnt[rtcal_pkg::SLOT_WEEKDAY]),
		.day_counter    (cnt[rtcal_pkg::SLOT_DAY]),
		.month_counter  (cnt[rtcal_pkg::SLOT_MONTH]),
		.second_carry   (second_carry),
		.tick64_carry   (tick64_carry),
		.tick64_read    (tick64_read),
		.carry_irq      (carry_irq),
		.alarm_irq      (alarm_irq),
		.irq            (irq)
	);

	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end

	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [32:0] e, input logic [32:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk(input string nm, input logic e, input logic g);
		cmp(nm, {32'h0, e}, {32'h0, g});
	endtask

	// One transfer; reads leave their expectation for the monitor
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd,
			input logic [32:0] e);
		int n = 0;
		@(posedge pclk);
		if (!wr) exp_q.push_back(e);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_count++;
			$display("Error pready expected 1 seen %b", pready);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		apb(1'b1, a, v, '0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic se);
		apb(1'b0, a, 8'h00, {se, 24'h0, e});
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task automatic pulse(input logic sec, input logic rdg);
		second_carry <= sec;
		tick64_carry <= ~sec;
		tick64_read <= rdg;
		@(posedge pclk);
		second_carry <= 1'b0;
		tick64_carry <= 1'b0;
		tick64_read <= 1'b0;
		idle(2);
	endtask

	function automatic logic [7:0] bcd(input int v);
		return {4'(v / 10), 4'(v % 10)};
	endfunction

	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (exp_q.size() == 0) begin
				err_count++;
				$display("Error read expected none seen %h", prdata);
			end else begin
				cmp("read", exp_q.pop_front(), {pslverr, prdata});
			end
		end
	end

	initial begin
		#200000;
		err_count++;
		test_done();
	end

	initial begin
		{presetn, manual_reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{second_carry, tick64_carry, tick64_read} = '0;
		pstrb = 4'hf;
		manual_reset_n = 1'b1;
		foreach (cnt[i]) cnt[i] = 8'h00;
		void'($urandom(44096));
		h = bcd($urandom_range(23));
		d = bcd($urandom_range(28, 1));
		wk = 8'($urandom_range(6));
		mo = bcd($urandom_range(12, 1));
		mi = bcd($urandom_range(59));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(rtcal_pkg::OFF_CONTROL, 8'h00, 1'b0);
		rd(8'h40, 8'h00, 1'b1);
		for (int i = 0; i < 6; i++) begin
			wr(rtcal_pkg::ALARM_OFF[i], 8'hff);
			rd(rtcal_pkg::ALARM_OFF[i], wmask[i], 1'b0);
		end
		// Power-on reset mid-run: enables drop, stored times stay
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) rd(rtcal_pkg::ALARM_OFF[i], wmask[i] & 8'h7f, 1'b0);
		rd(rtcal_pkg::OFF_CONTROL, 8'h00, 1'b0);
		// Values equal the counters, but nothing is enabled
		for (int i = 0; i < 6; i++) wr(rtcal_pkg::ALARM_OFF[i], 8'h00);
		idle(3);
		rd(rtcal_pkg::OFF_CONTROL, 8'h00, 1'b0);
		wr(rtcal_pkg::OFF_IRQ_MASK, 8'h03);
		wr(rtcal_pkg::OFF_CONTROL, 8'h08);
		cnt[rtcal_pkg::SLOT_HOUR] <= h ^ 8'h01;
		cnt[rtcal_pkg::SLOT_DAY] <= d;
		cnt[rtcal_pkg::SLOT_MINUTE] <= mi;
		wr(rtcal_pkg::OFF_HOUR_ALARM, 8'h80 | h);
		wr(rtcal_pkg::OFF_DAY_ALARM, 8'h80 | d);
		idle(3);
		rd(rtcal_pkg::OFF_CONTROL, 8'h08, 1'b0);
		cnt[rtcal_pkg::SLOT_HOUR] <= h;
		idle(3);
		chk("alarm_irq", 1'b1, alarm_irq);
		chk("irq", 1'b1, irq);
		rd(rtcal_pkg::OFF_CONTROL, 8'h09, 1'b0);
		wr(rtcal_pkg::OFF_CONTROL, 8'h09);
		rd(rtcal_pkg::OFF_CONTROL, 8'h09, 1'b0);
		wr(rtcal_pkg::OFF_CONTROL, 8'h00);
		rd(rtcal_pkg::OFF_CONTROL, 8'h00, 1'b0);
		rd(rtcal_pkg::OFF_IRQ_STATUS, 8'h02, 1'b0);
		rd(rtcal_pkg::OFF_IRQ_STATUS, 8'h00, 1'b0);
		idle(2);
		chk("alarm_irq", 1'b0, alarm_irq);
		chk("irq", 1'b0, irq);
		cnt[rtcal_pkg::SLOT_HOUR] <= h ^ 8'h01;
		idle(2);
		cnt[rtcal_pkg::SLOT_HOUR] <= h;
		idle(3);
		chk("alarm_irq", 1'b0, alarm_irq);
		wr(rtcal_pkg::OFF_CONTROL, 8'h10);
		pulse(1'b0, 1'b0);
		rd(rtcal_pkg::OFF_CONTROL, 8'h10, 1'b0);
		pulse(1'b0, 1'b1);
		chk("carry_irq", 1'b1, carry_irq);
		rd(rtcal_pkg::OFF_CONTROL, 8'h90, 1'b0);
		wr(rtcal_pkg::OFF_CONTROL, 8'h10);
		rd(rtcal_pkg::OFF_CONTROL, 8'h10, 1'b0);
		wr(rtcal_pkg::OFF_CONTROL, 8'h90);
		rd(rtcal_pkg::OFF_CONTROL, 8'h90, 1'b0);
		wr(rtcal_pkg::OFF_CONTROL, 8'h00);
		pulse(1'b1, 1'b0);
		chk("carry_irq", 1'b0, carry_irq);
		rd(rtcal_pkg::OFF_CONTROL, 8'h80, 1'b0);
		wr(rtcal_pkg::OFF_CONTROL, 8'hff);
		rd(rtcal_pkg::OFF_CONTROL, 8'h98, 1'b0);
		manual_reset_n <= 1'b0;
		idle(6);
		manual_reset_n <= 1'b1;
		idle(4);
		rd(rtcal_pkg::OFF_CONTROL, 8'h80, 1'b0);
		rd(rtcal_pkg::OFF_HOUR_ALARM, 8'h80 | h, 1'b0);
		// Lane 0 strobe low: the write must not land
		pstrb <= 4'he;
		wr(rtcal_pkg::OFF_HOUR_ALARM, 8'h00);
		pstrb <= 4'hf;
		rd(rtcal_pkg::OFF_HOUR_ALARM, 8'h80 | h, 1'b0);
		// Every slot enabled: the flag rises only once all six agree
		cnt[rtcal_pkg::SLOT_HOUR] <= h ^ 8'h01;
		cnt[rtcal_pkg::SLOT_WEEKDAY] <= wk;
		cnt[rtcal_pkg::SLOT_MONTH] <= mo;
		cnt[rtcal_pkg::SLOT_SECOND] <= mi;
		wr(rtcal_pkg::OFF_WEEKDAY_ALARM, 8'h80 | wk);
		wr(rtcal_pkg::OFF_MONTH_ALARM, 8'h80 | mo);
		wr(rtcal_pkg::OFF_SECOND_ALARM, 8'h80 | mi);
		wr(rtcal_pkg::OFF_MINUTE_ALARM, 8'h80 | mi);
		idle(3);
		rd(rtcal_pkg::OFF_CONTROL, 8'h80, 1'b0);
		cnt[rtcal_pkg::SLOT_HOUR] <= h;
		idle(3);
		rd(rtcal_pkg::OFF_CONTROL, 8'h81, 1'b0);
		idle(2);
		test_done();
	end
endmodule

`default_nettype wire
